// File: core/breaker_feedback_alarm_monitor.sv
// Breaker feedback mismatch monitor with horn, LED and acknowledge logic
//
// What this block does
// - Monitor only with second feedback option on
// - Decode closed, open, error from contacts
// - Monitoring on/off setting, default on
// - Alarm after equal inputs for delay
// - Selectable alarm class, default B
// - Self-acknowledge clears alarm once fault gone
// - Otherwise alarm latches until acknowledged
// - Lockable monitor checks only while unlocked
// - Not lockable ignores the lock condition
// - New B-F alarm flashes LED, sounds horn
// - Horn timeout: LED steady, horn off
// - Indicator ends only on acknowledgement
// - Zero horn time keeps horn until silenced or acknowledged
// - External ack: first silences, second acknowledges
// - External ack needs on-delay high, off-delay low
// - Second ack clears only inactive alarms
// - External ack defaults to second discrete input
// - Lock condition defaults to first discrete input
//
// Our own choices: the address map and the APB register port.
`timescale 1ns/10ps
`default_nettype none
module breaker_feedback_alarm_monitor
  import breaker_alarm_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic breaker_closed_feedback_in,
  input wire logic breaker_open_feedback_in,
  input wire logic ack_discrete_in,
  input wire logic lock_discrete_in,
  input wire logic ack_button_in,
  output logic breaker_feedback_mismatch_alarm,
  output logic horn_out,
  output logic led_flash_out,
  output logic led_steady_out,
  output logic irq
);

  typedef enum logic [1:0] {ACK_ARMED, ACK_HIGH, ACK_RELEASE} ack_state_type;

  logic [31:0] config_r;
  logic [13:0] delay_r;
  logic [9:0] horn_r;
  logic [13:0] ack_on_r;
  logic [13:0] ack_off_r;
  logic [IRQ_W-1:0] irq_stat_r;
  logic [IRQ_W-1:0] irq_mask_r;
  logic [31:0] tick_cnt_r;
  logic tick_r;
  logic fault_q;
  logic button_q;
  logic ext_stage_r;
  ack_state_type ack_state_r;
  logic [31:0] status_word;
  logic [31:0] rd_word;
  logic addr_ok;
  logic wr_en;
  logic cmd_ack;
  feedback_type fb_state;
  logic fb_error;
  logic lock_cond;
  logic ext_ack_cond;
  logic monitor_active;
  logic fault;
  logic new_alarm;
  logic loud_class;
  logic on_expired;
  logic off_expired;
  logic ext_pulse;
  logic full_ack;
  logic silence;
  logic horn_expired;
  logic alarm_clear;
  logic [IRQ_W-1:0] irq_events;
  alarm_class_type alarm_class;
  cond_src_type ack_src;
  cond_src_type lock_src;
  logic [13:0] delay_wr;
  logic [9:0] horn_wr;
  logic [TIMER_W-1:0] horn_limit;

  assign alarm_class = alarm_class_type'(config_r[CFG_CLASS_LO +: 3]);
  assign ack_src = cond_src_type'(config_r[CFG_ACK_SRC_LO +: 2]);
  assign lock_src = cond_src_type'(config_r[CFG_LOCK_SRC_LO +: 2]);

  // System tick for all timers
  always_ff @(posedge clk) begin
    if (rst || (tick_cnt_r == 32'(TICK_CYCLES - 1))) begin
      tick_cnt_r <= '0;
    end else begin
      tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      tick_r <= 1'b0;
    end else begin
      tick_r <= (tick_cnt_r == 32'(TICK_CYCLES - 1));
    end
  end

  assign fb_state = feedback_type'({breaker_closed_feedback_in,
                                     breaker_open_feedback_in});
  assign fb_error = (fb_state == FB_ERROR_LOW) || (fb_state == FB_ERROR_HIGH);

  // lock source, discrete input by default
  always_comb begin
    unique case (lock_src)
      SRC_DISCRETE: lock_cond = lock_discrete_in;
      SRC_SOFTWARE: lock_cond = config_r[CFG_SW_LOCK];
      SRC_EITHER: lock_cond = lock_discrete_in || config_r[CFG_SW_LOCK];
      SRC_NONE: lock_cond = 1'b0;
    endcase
  end

  // external ack source, discrete input by default
  always_comb begin
    unique case (ack_src)
      SRC_DISCRETE: ext_ack_cond = ack_discrete_in;
      SRC_SOFTWARE: ext_ack_cond = config_r[CFG_SW_EXT_ACK];
      SRC_EITHER: ext_ack_cond = ack_discrete_in || config_r[CFG_SW_EXT_ACK];
      SRC_NONE: ext_ack_cond = 1'b0;
    endcase
  end

  assign monitor_active = config_r[CFG_SECOND_FB] && config_r[CFG_MON_EN] &&
                          !(config_r[CFG_LOCKABLE] && lock_cond);

  tick_timer #(.W(TIMER_W)) mismatch_timer (
    .clk(clk),
    .rst(rst),
    .tick(tick_r),
    .run(monitor_active && fb_error),
    .limit({3'b000, delay_r}),
    .expired(fault)
  );

  tick_timer #(.W(TIMER_W)) ack_on_timer (
    .clk(clk),
    .rst(rst),
    .tick(tick_r),
    .run((ack_state_r == ACK_HIGH) && ext_ack_cond),
    .limit({3'b000, ack_on_r}),
    .expired(on_expired)
  );

  tick_timer #(.W(TIMER_W)) ack_off_timer (
    .clk(clk),
    .rst(rst),
    .tick(tick_r),
    .run((ack_state_r == ACK_RELEASE) && !ext_ack_cond),
    .limit({3'b000, ack_off_r}),
    .expired(off_expired)
  );

  assign horn_limit = TIMER_W'({7'h00, horn_r} * TICKS_PER_S);

  tick_timer #(.W(TIMER_W)) horn_timer (
    .clk(clk),
    .rst(rst),
    .tick(tick_r),
    .run(horn_out && (horn_r != 10'h000)),
    .limit(horn_limit),
    .expired(horn_expired)
  );

  // A high input that drops before the on-delay retries from ACK_HIGH
  always_ff @(posedge clk) begin
    if (rst) begin
      ack_state_r <= ACK_ARMED;
    end else begin
      unique case (ack_state_r)
        ACK_ARMED: if (!ext_ack_cond) ack_state_r <= ACK_HIGH;
        ACK_HIGH: if (on_expired) ack_state_r <= ACK_RELEASE;
        ACK_RELEASE: if (off_expired) ack_state_r <= ACK_HIGH;
      endcase
    end
  end

  assign ext_pulse = (ack_state_r == ACK_HIGH) && on_expired;

  always_ff @(posedge clk) begin
    if (rst) begin
      fault_q <= 1'b0;
      button_q <= 1'b0;
    end else begin
      fault_q <= fault;
      button_q <= ack_button_in;
    end
  end

  assign new_alarm = fault && !fault_q;
  assign cmd_ack = wr_en && (paddr == ADDR_COMMAND) && pwdata[CMD_ACK];
  assign full_ack = (ext_pulse && ext_stage_r) || cmd_ack ||
                    (ack_button_in && !button_q);
  assign silence = full_ack || (ext_pulse && !ext_stage_r);

  always_ff @(posedge clk) begin
    if (rst || cmd_ack || (ack_button_in && !button_q)) begin
      ext_stage_r <= 1'b0;
    end else if (ext_pulse) begin
      ext_stage_r <= !ext_stage_r;
    end
  end

  // only an inactive fault is cleared
  assign alarm_clear = breaker_feedback_mismatch_alarm && !fault &&
                       (config_r[CFG_SELF_ACK] || full_ack);

  always_ff @(posedge clk) begin
    if (rst) begin
      breaker_feedback_mismatch_alarm <= 1'b0;
    end else if (fault) begin
      breaker_feedback_mismatch_alarm <= 1'b1;
    end else if (alarm_clear) begin
      breaker_feedback_mismatch_alarm <= 1'b0;
    end
  end

  // class B to F drive horn and LED
  assign loud_class = (alarm_class != CLASS_A) &&
                      (alarm_class != CLASS_CONTROL);

  always_ff @(posedge clk) begin
    if (rst) begin
      horn_out <= 1'b0;
    end else if (new_alarm && loud_class) begin
      horn_out <= 1'b1;
    end else if (silence || horn_expired) begin
      horn_out <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      led_flash_out <= 1'b0;
      led_steady_out <= 1'b0;
    end else if (new_alarm && loud_class) begin
      led_flash_out <= 1'b1;
      led_steady_out <= 1'b0;
    end else if (full_ack) begin
      led_flash_out <= 1'b0;
      led_steady_out <= 1'b0;
    end else if (horn_expired && led_flash_out) begin
      led_flash_out <= 1'b0;
      led_steady_out <= 1'b1;
    end
  end

  // APB slave: zero wait states, answer in the first access cycle
  assign wr_en = psel && penable && pready && pwrite;
  assign addr_ok = (paddr[1:0] == 2'b00) && (paddr <= ADDR_IRQ_MASK);

  // Out-of-range timing values are pulled into the legal span
  assign delay_wr = (pwdata[13:0] < DELAY_MIN_CS) ? DELAY_MIN_CS :
                    (pwdata[13:0] > DELAY_MAX_CS) ? DELAY_MAX_CS :
                    pwdata[13:0];
  assign horn_wr = (pwdata[9:0] > HORN_MAX_S) ? HORN_MAX_S : pwdata[9:0];

  always_ff @(posedge clk) begin
    if (rst) begin
      config_r <= CONFIG_RESET;
      delay_r <= DELAY_DEF_CS;
      horn_r <= HORN_DEF_S;
      ack_on_r <= ACK_ON_DEF_CS;
      ack_off_r <= ACK_OFF_DEF_CS;
      irq_mask_r <= '0;
    end else if (wr_en) begin
      unique case (paddr)
        ADDR_CONFIG: config_r <= {18'h00000, pwdata[13:8], 1'b0,
                                  pwdata[6:0]};
        ADDR_DELAY: delay_r <= delay_wr;
        ADDR_HORN: horn_r <= horn_wr;
        ADDR_ACK_DELAY: begin
          ack_on_r <= pwdata[13:0];
          ack_off_r <= pwdata[ACK_OFF_LO +: 14];
        end
        ADDR_IRQ_MASK: irq_mask_r <= pwdata[IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  assign irq_events = {ext_pulse, alarm_clear, new_alarm};

  // Set beats a simultaneous write-one clear
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_stat_r <= '0;
    end else if (wr_en && (paddr == ADDR_IRQ_STATUS)) begin
      irq_stat_r <= (irq_stat_r & ~pwdata[IRQ_W-1:0]) | irq_events;
    end else begin
      irq_stat_r <= irq_stat_r | irq_events;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat_r & irq_mask_r);
    end
  end

  assign status_word = {23'h000000, ext_stage_r, lock_cond, led_steady_out,
                        led_flash_out, horn_out,
                        breaker_feedback_mismatch_alarm, fault, fb_state};

  always_comb begin
    unique case (paddr)
      ADDR_CONFIG: rd_word = config_r;
      ADDR_DELAY: rd_word = {18'h00000, delay_r};
      ADDR_HORN: rd_word = {22'h000000, horn_r};
      ADDR_ACK_DELAY: rd_word = {2'b00, ack_off_r, 2'b00, ack_on_r};
      ADDR_STATUS: rd_word = status_word;
      ADDR_IRQ_STATUS: rd_word = {29'h00000000, irq_stat_r};
      ADDR_IRQ_MASK: rd_word = {29'h00000000, irq_mask_r};
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // Answer prepared in the setup cycle so outputs stay registered
  always_ff @(posedge clk) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok;
      prdata <= (psel && !penable && !pwrite) ? rd_word : 32'h0000_0000;
    end
  end

endmodule // breaker_feedback_alarm_monitor
`default_nettype wire

// File: inc/breaker_alarm_pkg.sv
// Constants, register map and types for the breaker feedback alarm monitor
package breaker_alarm_pkg;

  localparam int CLK_MHZ = 250;
  localparam int TICK_TIME_MS = 10;
  localparam int TICK_CYCLES_DEF = TICK_TIME_MS * 1000 * CLK_MHZ;
  localparam int TIMER_W = 17;
  localparam logic [16:0] TICKS_PER_S = 17'h00064;

  localparam logic [7:0] ADDR_CONFIG = 8'h00;
  localparam logic [7:0] ADDR_DELAY = 8'h04;
  localparam logic [7:0] ADDR_HORN = 8'h08;
  localparam logic [7:0] ADDR_ACK_DELAY = 8'h0C;
  localparam logic [7:0] ADDR_COMMAND = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h18;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h1C;

  localparam int CFG_MON_EN = 0;
  localparam int CFG_SECOND_FB = 1;
  localparam int CFG_SELF_ACK = 2;
  localparam int CFG_LOCKABLE = 3;
  localparam int CFG_CLASS_LO = 4;
  localparam int CFG_ACK_SRC_LO = 8;
  localparam int CFG_LOCK_SRC_LO = 10;
  localparam int CFG_SW_EXT_ACK = 12;
  localparam int CFG_SW_LOCK = 13;
  localparam int CMD_ACK = 0;
  localparam int ACK_OFF_LO = 16;

  localparam logic [13:0] DELAY_MIN_CS = 14'h0002;
  localparam logic [13:0] DELAY_MAX_CS = 14'h270F;
  localparam logic [13:0] DELAY_DEF_CS = 14'h03E8;
  localparam logic [9:0] HORN_MAX_S = 10'h3E8;
  localparam logic [9:0] HORN_DEF_S = 10'h00A;
  localparam logic [13:0] ACK_ON_DEF_CS = 14'h0000;
  localparam logic [13:0] ACK_OFF_DEF_CS = 14'h0000;

  localparam int IRQ_NEW_ALARM = 0;
  localparam int IRQ_ALARM_CLEARED = 1;
  localparam int IRQ_EXT_ACK = 2;
  localparam int IRQ_W = 3;

  typedef enum logic [2:0] {
    CLASS_A, CLASS_B, CLASS_C, CLASS_D, CLASS_E, CLASS_F, CLASS_CONTROL
  } alarm_class_type;

  // Source selection for the acknowledge and lock conditions
  typedef enum logic [1:0] {
    SRC_DISCRETE, SRC_SOFTWARE, SRC_EITHER, SRC_NONE
  } cond_src_type;

  typedef enum logic [1:0] {
    FB_ERROR_LOW, FB_OPEN, FB_CLOSED, FB_ERROR_HIGH
  } feedback_type;

  localparam logic [31:0] CONFIG_RESET = 32'h0000_0013;

endpackage

// File: core/tick_timer.sv
// Tick-counting delay qualifier: expires once run has held for limit ticks
`timescale 1ns/10ps
`default_nettype none
module tick_timer #(
  parameter int W = 17
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic tick,
  input wire logic run,
  input wire logic [W-1:0] limit,
  output logic expired
);

  logic [W-1:0] count_r;

  // Any drop of run restarts from zero
  always_ff @(posedge clk) begin
    if (rst || !run) begin
      count_r <= '0;
    end else if (tick && (count_r < limit)) begin
      count_r <= count_r + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      expired <= 1'b0;
    end else begin
      expired <= run && (count_r >= limit);
    end
  end

endmodule // tick_timer
`default_nettype wire

// File: tb/breaker_alarm_chk.sv
// Port-level checker for the breaker feedback alarm monitor
`timescale 1ns/10ps
`default_nettype none
module breaker_alarm_chk #(
  parameter int TICK_CYCLES = 10
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic breaker_closed_feedback_in,
  input wire logic breaker_open_feedback_in,
  input wire logic ack_discrete_in,
  input wire logic ack_button_in,
  input wire logic breaker_feedback_mismatch_alarm,
  input wire logic horn_out,
  input wire logic led_flash_out,
  input wire logic led_steady_out
);
  // Tick phase may shave up to one tick off the shortest delay
  localparam int MIN_EQ = TICK_CYCLES / 2;
  logic [15:0] eq_cnt_r;
  logic [3:0] ack_age_r;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  always_ff @(posedge clk) begin
    if (rst || breaker_closed_feedback_in != breaker_open_feedback_in)
      eq_cnt_r <= '0;
    else if (eq_cnt_r != 16'hFFFF)
      eq_cnt_r <= eq_cnt_r + 16'h0001;
  end
  always_ff @(posedge clk) begin
    if (rst || ack_button_in || ack_discrete_in || (psel && pwrite))
      ack_age_r <= '0;
    else if (ack_age_r != 4'hF)
      ack_age_r <= ack_age_r + 4'h1;
  end
  a_apb_ready: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_apb_idle: assert property (!psel |=> !pready)
    else $error("ready without transfer");
  a_mismatch_delay: assert property (
    $rose(breaker_feedback_mismatch_alarm) |-> $past(eq_cnt_r, 3) >= MIN_EQ)
    else $error("alarm before contacts held equal");
  a_led_onehot: assert property (
    !(led_flash_out && led_steady_out)) else $error("both leds lit");
  a_steady_quiet: assert property (
    led_steady_out |-> !horn_out) else $error("horn with steady led");
  a_steady_from_flash: assert property (
    $rose(led_steady_out) |-> $past(led_flash_out))
    else $error("steady led without flashing");
  a_horn_flash: assert property (
    $rose(horn_out) |-> led_flash_out && breaker_feedback_mismatch_alarm)
    else $error("horn without flashing alarm");
  a_led_needs_ack: assert property (
    ($fell(led_flash_out) && !led_steady_out) ||
    ($fell(led_steady_out) && !led_flash_out)
    |-> ack_age_r < 4'h6) else $error("led cleared without ack");
  c_alarm: cover property ($rose(breaker_feedback_mismatch_alarm));
  c_steady: cover property ($rose(led_steady_out));
  c_cleared: cover property ($fell(breaker_feedback_mismatch_alarm));
endmodule // breaker_alarm_chk
bind breaker_feedback_alarm_monitor breaker_alarm_chk #(
  .TICK_CYCLES(TICK_CYCLES)) chk (.clk(clk), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pready(pready),
  .breaker_closed_feedback_in(breaker_closed_feedback_in),
  .breaker_open_feedback_in(breaker_open_feedback_in),
  .ack_discrete_in(ack_discrete_in), .ack_button_in(ack_button_in),
  .breaker_feedback_mismatch_alarm(breaker_feedback_mismatch_alarm),
  .horn_out(horn_out), .led_flash_out(led_flash_out),
  .led_steady_out(led_steady_out));
`default_nettype wire

// File: tb/breaker_field_model.sv
// Breaker auxiliary contacts and operator discrete inputs
`timescale 1ns/10ps
`default_nettype none
module breaker_field_model
  import breaker_alarm_pkg::*;
(
  input wire logic clk,
  output logic closed_fb,
  output logic open_fb,
  output logic ack_in,
  output logic lock_in,
  output logic button
);
  initial begin
    closed_fb = 1'b0;
    open_fb = 1'b1;
    ack_in = 1'b0;
    lock_in = 1'b0;
    button = 1'b0;
  end
  task automatic set_pos(input feedback_type p);
    @(posedge clk);
    {closed_fb, open_fb} <= p;
  endtask
  task automatic set_lock(input logic v);
    @(posedge clk);
    lock_in <= v;
  endtask
  task automatic press();
    @(posedge clk);
    button <= 1'b1;
    repeat (4) @(posedge clk);
    button <= 1'b0;
  endtask
  task automatic ext_ack(input int hi, input int lo);
    @(posedge clk);
    ack_in <= 1'b1;
    repeat (hi) @(posedge clk);
    ack_in <= 1'b0;
    repeat (lo) @(posedge clk);
  endtask
endmodule // breaker_field_model
`default_nettype wire

// File: tb/tb_breaker_feedback_alarm_monitor.sv
// Self-checking bench for the breaker feedback alarm monitor
`timescale 1ns/10ps
`default_nettype none
module tb_breaker_feedback_alarm_monitor;
  import breaker_alarm_pkg::*;
  localparam int TC = 10;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, cfb, ofb, ack, lck, btn;
  logic alarm, horn, flash, steady, irq;
  int n_mismatch = 0;
  int n_compared = 0;
  always #2 clk = ~clk;
  breaker_feedback_alarm_monitor #(.TICK_CYCLES(TC)) DUT (.clk(clk),
    .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .breaker_closed_feedback_in(cfb),
    .breaker_open_feedback_in(ofb), .ack_discrete_in(ack),
    .lock_discrete_in(lck), .ack_button_in(btn),
    .breaker_feedback_mismatch_alarm(alarm), .horn_out(horn),
    .led_flash_out(flash), .led_steady_out(steady), .irq(irq));
  breaker_field_model fm (.clk(clk), .closed_fb(cfb), .open_fb(ofb),
    .ack_in(ack), .lock_in(lck), .button(btn));
  function automatic logic [31:0] b(input logic x);
    return {31'h0, x};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t: got %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    // No local limit: only the watchdog may end a stalled transfer
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd32(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task automatic wait_for(ref logic s, input logic v, input int max);
    int n;
    n = 0;
    while (s !== v && n < max) begin
      @(posedge clk);
      n++;
    end
    chk(b(s), b(v));
  endtask
  task automatic t_regs();
    rd32(ADDR_CONFIG, 32'h0000_0013);
    rd32(ADDR_DELAY, 32'h0000_03E8);
    rd32(ADDR_HORN, 32'h0000_000A);
    wr(ADDR_DELAY, 32'h0000_0001);
    rd32(ADDR_DELAY, 32'h0000_0002);
    wr(ADDR_DELAY, 32'h0000_3FFF);
    rd32(ADDR_DELAY, 32'h0000_270F);
    rd32(8'h20, 32'h0000_0000);
    chk(b(err), 32'h1);
    wr(ADDR_DELAY, 32'h0000_0002);
    wr(ADDR_HORN, 32'h0000_0001);
    wr(ADDR_IRQ_MASK, 32'h0000_0007);
    wr(ADDR_ACK_DELAY, 32'h0002_0002);
  endtask
  // Equal spells shorter than a tick must never add up
  task automatic t_restart();
    repeat (4) begin
      fm.set_pos(FB_ERROR_LOW);
      repeat (TC - 3) @(posedge clk);
      fm.set_pos(FB_OPEN);
      repeat (2) @(posedge clk);
    end
    repeat (5) @(posedge clk);
    chk(b(alarm), 32'h0);
  endtask
  task automatic t_latch();
    fm.set_pos(FB_ERROR_LOW);
    wait_for(alarm, 1'b1, 4 * TC);
    repeat (3) @(posedge clk);
    chk(b(horn), 32'h1);
    chk(b(flash), 32'h1);
    chk(b(irq), 32'h1);
    fm.set_pos(FB_CLOSED);
    wait_for(steady, 1'b1, 110 * TC);
    chk(b(horn), 32'h0);
    fm.ext_ack(8, 60);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rd & 32'h108, 32'h008);
    fm.ext_ack(60, 1);
    fm.ext_ack(60, 60);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rd & 32'h108, 32'h108);
    fm.ext_ack(60, 60);
    chk(b(alarm), 32'h0);
    chk(b(steady), 32'h0);
    wr(ADDR_IRQ_STATUS, 32'h0000_0007);
    rd32(ADDR_IRQ_STATUS, 32'h0);
    chk(b(irq), 32'h0);
  endtask
  task automatic t_active();
    wr(ADDR_HORN, 32'h0);
    wr(ADDR_IRQ_MASK, 32'h0);
    fm.set_pos(FB_ERROR_HIGH);
    wait_for(alarm, 1'b1, 4 * TC);
    repeat (120 * TC) @(posedge clk);
    chk(b(horn), 32'h1);
    chk(b(irq), 32'h0);
    apb(1'b0, ADDR_IRQ_STATUS, 32'h0);
    chk(rd & 32'h1, 32'h1);
    fm.press();
    repeat (4) @(posedge clk);
    chk(b(alarm), 32'h1);
    fm.set_pos(FB_OPEN);
    repeat (4) @(posedge clk);
    chk(b(alarm), 32'h1);
    fm.press();
    repeat (4) @(posedge clk);
    chk(b(alarm), 32'h0);
  endtask
  task automatic t_gate(input logic [31:0] cfg, input logic lk,
                        input logic ea, input logic eh);
    wr(ADDR_CONFIG, cfg);
    fm.set_lock(lk);
    fm.set_pos(FB_ERROR_LOW);
    repeat (5 * TC) @(posedge clk);
    chk(b(alarm), b(ea));
    chk(b(horn), b(eh));
    fm.set_pos(FB_OPEN);
    fm.set_lock(1'b0);
    wr(ADDR_COMMAND, 32'h1);
    repeat (3) @(posedge clk);
    chk(b(alarm), 32'h0);
  endtask
  task automatic t_self();
    wr(ADDR_CONFIG, 32'h17);
    fm.set_pos(FB_ERROR_LOW);
    wait_for(alarm, 1'b1, 4 * TC);
    fm.set_pos(FB_CLOSED);
    wait_for(alarm, 1'b0, 8);
    chk(b(flash), 32'h1);
    wr(ADDR_COMMAND, 32'h1);
    repeat (3) @(posedge clk);
    chk(b(flash), 32'h0);
  endtask
  task automatic give_verdict();
    $display("compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #80000;
    n_mismatch++;
    give_verdict();
  end
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_restart();
    t_latch();
    t_active();
    t_gate(32'h12, 1'b0, 1'b0, 1'b0);
    t_gate(32'h11, 1'b0, 1'b0, 1'b0);
    t_gate(32'h1B, 1'b1, 1'b0, 1'b0);
    t_gate(32'h1B, 1'b0, 1'b1, 1'b1);
    t_gate(32'h13, 1'b1, 1'b1, 1'b1);
    t_gate(32'h03, 1'b0, 1'b1, 1'b0);
    t_gate(32'h63, 1'b0, 1'b1, 1'b0);
    t_gate(32'h53, 1'b0, 1'b1, 1'b1);
    t_gate(32'h241B, 1'b0, 1'b0, 1'b0);
    t_self();
    give_verdict();
  end
endmodule // tb_breaker_feedback_alarm_monitor
`default_nettype wire
